// [rtl/wiso_regs.svh]
`ifndef WISO_REGS_SVH
`define WISO_REGS_SVH

// ----------------------------------------------------------------
// widths
// ----------------------------------------------------------------
`define DATA_W 32
`define SEQ_W 5
`define IE_ID_W 8
`define IE_CNT_W 8
`define ALT_W 8
`define MPS_W 16
`define EXP_W 5
`define CYC_W 32

// ----------------------------------------------------------------
// defaults and codes
// ----------------------------------------------------------------
`define IN_DEPTH_DEF 8
`define OUT_DEPTH_DEF 2
`define MAX_SEQ_DEF 32
`define MAX_PKT_DEF 16'h0200
`define ZERO_PKT 16'h0000
`define DEFAULT_ALT 8'h00
`define HS_ACK_CODE 2'h0
`define HS_NAK_CODE 2'h1

// ----------------------------------------------------------------
// service interval timing
// ----------------------------------------------------------------
`define MCLK_MHZ 100
`define SI_UNIT_US 128
`define SI_EXP_MIN 5'h06
`define SI_EXP_MAX 5'h10
`define SI_EXP_ONE 5'h01

`endif

// [rtl/wiso_pkg.sv]
`include "wiso_regs.svh"

package wiso_pkg;

  // ----------------------------------------------------------------
  // handshake codes, no stall code exists
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    HS_ACK = `HS_ACK_CODE,
    HS_NAK = `HS_NAK_CODE
  } hs_t;

  // ----------------------------------------------------------------
  // data packet with burst sequence number
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [`SEQ_W-1:0] seq;
    logic [`DATA_W-1:0] data;
  } pkt_t;

  // ----------------------------------------------------------------
  // discard information element
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [`IE_ID_W-1:0] id;
    logic [`SEQ_W-1:0] window;
    logic [`IE_CNT_W-1:0] count;
  } ie_t;

  // ----------------------------------------------------------------
  // in side states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    IN_IDLE = 2'h0,
    IN_WAIT = 2'h1,
    IN_FLOW = 2'h3
  } in_state_t;

endpackage

// [rtl/wiso_fifo.sv]
`timescale 1ns/1ps
`include "wiso_regs.svh"

module wiso_fifo #(
  parameter int WIDTH = `DATA_W,
  parameter int DEPTH = `OUT_DEPTH_DEF
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [WIDTH-1:0] next_mem [DEPTH];
  logic [PW-1:0] wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
  logic [CW-1:0] count, next_count;
  logic push, pop;

  assign in_ready = (count != FULL);
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    next_mem = mem;
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count = count;
    if (push) begin
      next_mem[wr_ptr] = in_data;
      next_wr_ptr = (wr_ptr == LAST) ? '0 : wr_ptr + 1'b1;
    end
    if (pop) begin
      next_rd_ptr = (rd_ptr == LAST) ? '0 : rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    mem <= next_mem;
    if (!reset_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end

endmodule // wiso_fifo

// [rtl/wiso_interval.sv]
`timescale 1ns/1ps
`include "wiso_regs.svh"

module wiso_interval #(
  parameter int UNIT_CYCLES = `SI_UNIT_US * `MCLK_MHZ
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [`EXP_W-1:0] req_exp,
  output logic [`EXP_W-1:0] code,
  output logic [`CYC_W-1:0] cycles
);
  logic [`EXP_W-1:0] next_code;
  logic [`CYC_W-1:0] next_cycles;

  // ----------------------------------------------------------------
  // clamp exponent, length is 2^(x-1) units
  // ----------------------------------------------------------------
  always_comb begin
    if (req_exp < `SI_EXP_MIN) begin
      next_code = `SI_EXP_MIN; // R2
    end else if (req_exp > `SI_EXP_MAX) begin
      next_code = `SI_EXP_MAX; // R2
    end else begin
      next_code = req_exp;
    end
    next_cycles = `CYC_W'(UNIT_CYCLES) << (next_code - `SI_EXP_ONE); // R2
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      code <= `SI_EXP_MIN;
      cycles <= '0;
    end else begin
      code <= next_code;
      cycles <= next_cycles;
    end
  end

endmodule // wiso_interval

// [rtl/wiso_endpoint.sv]
`timescale 1ns/1ps
`include "wiso_regs.svh"

// Overview of operation
// R1: host caps periodic channel time at 80 percent
// R2: interval exponent 6 to 16, 2^(x-1)*128us
// R3: no fixed spacing assumed between attempts
// R4: empty in endpoint answers a request with nak
// R5: out endpoint naks when no room
// R6: handshaked burst sequence delivery with retries
// R7: configuration transfers reset tx and rx windows
// R8: host resumes service next interval after nak
// R9: no endpoint ready notification after flow control
// R10: in storage full drops oldest data only
// R11: remaining packets reuse dropped sequence numbers
// R12: host orders in data by presentation time
// R13: never answer with a stall handshake
// R14: host drops out packets only when stale
// R15: host never reuses a dropped out sequence
// R16: host reports discards with discard element
// R17: host puts discard element before allocations
// R18: host grants a device transmit slot with element
// R19: host repeats element until device confirms
// R20: element id fixed until confirmed, then incremented
// R21: discard element sets out receive window
// R22: default setting reports zero max packet size
// R23: element applied once per identifier
module wiso_endpoint #(
  parameter int IN_DEPTH = `IN_DEPTH_DEF,
  parameter int OUT_DEPTH = `OUT_DEPTH_DEF,
  parameter int MAX_SEQ = `MAX_SEQ_DEF,
  parameter logic [`MPS_W-1:0] MAX_PKT = `MAX_PKT_DEF,
  parameter int UNIT_CYCLES = `SI_UNIT_US * `MCLK_MHZ
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [`ALT_W-1:0] alt_setting,
  input wire logic [`EXP_W-1:0] interval_req,
  input wire logic cfg_reset,
  output logic [`MPS_W-1:0] max_packet_size,
  output logic [`EXP_W-1:0] interval_code,
  output logic [`CYC_W-1:0] interval_cycles,
  output logic ep_ready_notify,
  input wire logic src_valid,
  input wire logic [`DATA_W-1:0] src_data,
  output logic in_discard,
  input wire logic in_req,
  input wire logic in_ack,
  output logic in_rsp_valid,
  output logic in_rsp_nak,
  output wiso_pkg::pkt_t in_rsp_pkt,
  input wire logic out_valid,
  input wire wiso_pkg::pkt_t out_pkt,
  output logic out_hs_valid,
  output wiso_pkg::hs_t out_hs,
  output logic sink_valid,
  input wire logic sink_ready,
  output logic [`DATA_W-1:0] sink_data,
  input wire logic ie_valid,
  input wire wiso_pkg::ie_t ie,
  output logic ie_confirm,
  output logic [`IE_CNT_W-1:0] lost_count
);
  import wiso_pkg::*;

  localparam int PW = (IN_DEPTH > 1) ? $clog2(IN_DEPTH) : 1;
  localparam int CW = $clog2(IN_DEPTH + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(IN_DEPTH);
  localparam logic [`SEQ_W-1:0] SEQ_LAST = `SEQ_W'(MAX_SEQ - 1);

  function automatic logic [`SEQ_W-1:0] seq_inc(
    input logic [`SEQ_W-1:0] s
  );
    seq_inc = (s == SEQ_LAST) ? '0 : s + 1'b1;
  endfunction

  // ----------------------------------------------------------------
  // descriptor side
  // ----------------------------------------------------------------
  logic [`MPS_W-1:0] next_max_packet_size;

  wiso_interval #(
    .UNIT_CYCLES(UNIT_CYCLES)
  ) u_interval (
    .mclk(mclk),
    .reset_n(reset_n),
    .req_exp(interval_req),
    .code(interval_code),
    .cycles(interval_cycles)
  ); // R2

  always_comb begin
    if (alt_setting == `DEFAULT_ALT) begin
      next_max_packet_size = `ZERO_PKT; // R22
    end else begin
      next_max_packet_size = MAX_PKT;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      max_packet_size <= `ZERO_PKT;
      ep_ready_notify <= 1'b0;
    end else begin
      max_packet_size <= next_max_packet_size;
      ep_ready_notify <= 1'b0; // R9
    end
  end

  // ----------------------------------------------------------------
  // in storage and transmit window
  // ----------------------------------------------------------------
  logic [`DATA_W-1:0] store [IN_DEPTH];
  logic [`DATA_W-1:0] next_store [IN_DEPTH];
  logic [PW-1:0] wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
  logic [CW-1:0] count, next_count;
  logic [`SEQ_W-1:0] tx_seq, next_tx_seq;
  in_state_t in_state, next_in_state;
  logic next_in_rsp_valid, next_in_rsp_nak, next_in_discard;
  pkt_t next_in_rsp_pkt;
  logic pop, drop;

  always_comb begin
    pop = (in_state == IN_WAIT) && in_ack; // R6
    drop = src_valid && (count == FULL_CNT) && !pop; // R10
    next_store = store;
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count = count;
    next_tx_seq = tx_seq;
    next_in_state = in_state;
    next_in_rsp_valid = 1'b0;
    next_in_rsp_nak = 1'b0;
    next_in_rsp_pkt = in_rsp_pkt;
    next_in_discard = drop;
    if (src_valid) begin
      next_store[wr_ptr] = src_data;
      next_wr_ptr = wr_ptr + 1'b1;
    end
    if (pop || drop) begin
      next_rd_ptr = rd_ptr + 1'b1; // R10
    end
    if (src_valid && !drop && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !src_valid) begin
      next_count = count - 1'b1;
    end
    if (pop) begin
      next_tx_seq = seq_inc(tx_seq); // R6
      next_in_state = IN_IDLE;
    end
    if (drop && in_state == IN_WAIT) begin
      // sent packet is gone, next oldest goes out under tx_seq
      next_in_state = IN_IDLE; // R11
    end
    // every request outside a cfg_reset cycle is served as it comes, no timer on attempts
    if (in_req) begin // R3
      next_in_rsp_valid = 1'b1;
      if (next_count == '0) begin
        next_in_rsp_nak = 1'b1; // R4
        next_in_state = IN_FLOW; // R9
      end else begin
        next_in_rsp_pkt.data = next_store[next_rd_ptr];
        next_in_rsp_pkt.seq = next_tx_seq; // R11
        next_in_state = IN_WAIT; // R6
      end
    end
    if (cfg_reset) begin
      next_rd_ptr = '0;
      next_wr_ptr = '0;
      next_count = '0;
      next_tx_seq = '0; // R7
      next_in_state = IN_IDLE; // R7
      next_in_rsp_valid = 1'b0;
      next_in_discard = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    store <= next_store;
    if (!reset_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      tx_seq <= '0;
      in_state <= IN_IDLE;
      in_rsp_valid <= 1'b0;
      in_rsp_nak <= 1'b0;
      in_rsp_pkt <= '0;
      in_discard <= 1'b0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
      tx_seq <= next_tx_seq;
      in_state <= next_in_state;
      in_rsp_valid <= next_in_rsp_valid;
      in_rsp_nak <= next_in_rsp_nak;
      in_rsp_pkt <= next_in_rsp_pkt;
      in_discard <= next_in_discard;
    end
  end

  // ----------------------------------------------------------------
  // out receive window and discard element
  // ----------------------------------------------------------------
  logic [`SEQ_W-1:0] rx_window, next_rx_window, rx_prev;
  logic [`IE_ID_W-1:0] last_id, next_last_id;
  logic id_valid, next_id_valid;
  logic next_out_hs_valid, next_ie_confirm;
  hs_t next_out_hs;
  logic [`IE_CNT_W-1:0] next_lost_count;
  logic buf_ready, buf_push;

  always_comb begin
    rx_prev = (rx_window == '0) ? SEQ_LAST : rx_window - 1'b1;
    next_rx_window = rx_window;
    next_last_id = last_id;
    next_id_valid = id_valid;
    next_out_hs_valid = 1'b0;
    next_out_hs = out_hs;
    next_ie_confirm = 1'b0;
    next_lost_count = lost_count;
    buf_push = 1'b0;
    if (out_valid) begin
      next_out_hs_valid = 1'b1;
      if (out_pkt.seq == rx_window) begin
        if (buf_ready) begin
          buf_push = 1'b1;
          next_out_hs = HS_ACK; // R13
          next_rx_window = seq_inc(rx_window); // R6
        end else begin
          next_out_hs = HS_NAK; // R5
        end
      end else if (out_pkt.seq == rx_prev) begin
        next_out_hs = HS_ACK; // R6
      end else begin
        next_out_hs = HS_NAK; // R13
      end
    end
    if (ie_valid) begin
      next_ie_confirm = 1'b1;
      if (!id_valid || ie.id != last_id) begin // R23
        next_rx_window = ie.window; // R21
        next_last_id = ie.id; // R23
        next_id_valid = 1'b1;
        next_lost_count = lost_count + ie.count;
      end
    end
    if (cfg_reset) begin
      next_rx_window = '0; // R7
      next_id_valid = 1'b0;
      next_out_hs_valid = 1'b0;
      next_ie_confirm = 1'b0;
      buf_push = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      rx_window <= '0;
      last_id <= '0;
      id_valid <= 1'b0;
      out_hs_valid <= 1'b0;
      out_hs <= HS_ACK;
      ie_confirm <= 1'b0;
      lost_count <= '0;
    end else begin
      rx_window <= next_rx_window;
      last_id <= next_last_id;
      id_valid <= next_id_valid;
      out_hs_valid <= next_out_hs_valid;
      out_hs <= next_out_hs;
      ie_confirm <= next_ie_confirm;
      lost_count <= next_lost_count;
    end
  end

  // ----------------------------------------------------------------
  // out data buffer toward the user
  // ----------------------------------------------------------------
  wiso_fifo #(
    .WIDTH(`DATA_W),
    .DEPTH(OUT_DEPTH)
  ) u_out_buf (
    .mclk(mclk),
    .reset_n(reset_n),
    .in_valid(buf_push),
    .in_ready(buf_ready),
    .in_data(out_pkt.data),
    .out_valid(sink_valid),
    .out_ready(sink_ready),
    .out_data(sink_data)
  ); // R5

endmodule // wiso_endpoint

// [testbench/wiso_endpoint_asserts.sv]
`timescale 1ns/1ps

module wiso_endpoint_asserts #(
  parameter int UNIT_CYCLES = 4,
  parameter logic [15:0] MAX_PKT = 16'h0200
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [7:0] alt_setting,
  input wire logic [4:0] interval_req,
  input wire logic cfg_reset,
  input wire logic [15:0] max_packet_size,
  input wire logic [4:0] interval_code,
  input wire logic [31:0] interval_cycles,
  input wire logic ep_ready_notify,
  input wire logic src_valid,
  input wire logic in_discard,
  input wire logic in_req,
  input wire logic in_rsp_valid,
  input wire logic in_rsp_nak,
  input wire logic out_valid,
  input wire logic out_hs_valid,
  input wire wiso_pkg::hs_t out_hs,
  input wire logic sink_valid,
  input wire logic sink_ready,
  input wire logic [31:0] sink_data
);
  import wiso_pkg::*;
  // --
  // clamped exponent
  // --
  logic [4:0] clamp;
  always_comb begin
    clamp = interval_req < 5'h06 ? 5'h06 :
      (interval_req > 5'h10 ? 5'h10 : interval_req);
  end
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!reset_n);
  // --
  // checks
  // --
  a_in_answer: assert property (
    1 |=> in_rsp_valid == ($past(in_req) && !$past(cfg_reset)))
    else $error("in answer timing wrong");
  a_out_answer: assert property (
    out_valid && !cfg_reset |=> out_hs_valid)
    else $error("out packet not answered");
  a_no_stall: assert property (
    out_hs_valid |-> out_hs inside {HS_ACK, HS_NAK})
    else $error("bad handshake code");
  a_no_notify: assert property (!ep_ready_notify)
    else $error("ready notification sent");
  a_default_zero: assert property (1 |=> max_packet_size ==
    ($past(alt_setting) == 8'h00 ? 16'h0000 : MAX_PKT))
    else $error("packet size wrong");
  a_code_clamp: assert property (
    1 |=> interval_code == $past(clamp))
    else $error("interval code wrong");
  a_cycles_match: assert property ($past(reset_n) |->
    interval_cycles == (32'(UNIT_CYCLES) << (interval_code - 5'h01)))
    else $error("interval length wrong");
  a_drop_cause: assert property (in_discard |-> $past(src_valid))
    else $error("drop without push");
  a_sink_hold: assert property (
    sink_valid && !sink_ready && !cfg_reset |=>
    sink_valid && $stable(sink_data))
    else $error("sink word lost");
  c_in_data: cover property (in_rsp_valid && !in_rsp_nak);
  c_out_nak: cover property (out_hs_valid && out_hs == HS_NAK);
  c_drop: cover property (in_discard);
endmodule // wiso_endpoint_asserts

bind wiso_endpoint wiso_endpoint_asserts #(
  .UNIT_CYCLES(UNIT_CYCLES),
  .MAX_PKT(MAX_PKT)
) u_chk (
  .mclk, .reset_n, .alt_setting, .interval_req, .cfg_reset,
  .max_packet_size, .interval_code, .interval_cycles, .ep_ready_notify,
  .src_valid, .in_discard, .in_req, .in_rsp_valid, .in_rsp_nak,
  .out_valid, .out_hs_valid, .out_hs, .sink_valid, .sink_ready,
  .sink_data
);

// [testbench/wiso_host.sv]
`timescale 1ns/1ps

module wiso_host (
  input wire logic mclk,
  output logic in_req,
  output logic in_ack,
  output logic out_valid,
  output wiso_pkg::pkt_t out_pkt,
  output logic ie_valid,
  output wiso_pkg::ie_t ie,
  output logic cfg_reset
);
  import wiso_pkg::*;
  logic [7:0] id = 8'h00;
  initial begin
    in_req = 0;
    in_ack = 0;
    out_valid = 0;
    ie_valid = 0;
    cfg_reset = 0;
    out_pkt = '0;
    ie = '0;
  end
  // --
  // host transactions
  // --
  task automatic tok(input logic a);
    @(negedge mclk);
    in_req = !a;
    in_ack = a;
    @(negedge mclk);
    in_req = 0;
    in_ack = 0;
  endtask
  task automatic out(input logic [4:0] s, input logic [31:0] d);
    @(negedge mclk);
    out_valid = 1;
    out_pkt = {s, d};
    @(negedge mclk);
    out_valid = 0;
    out_pkt = ~out_pkt;
  endtask
  task automatic disc(input bit f, input logic [4:0] w,
                      input logic [7:0] c);
    if (f) id = id + 8'h01;
    @(negedge mclk);
    ie_valid = 1;
    ie = {id, w, c};
    @(negedge mclk);
    ie_valid = 0;
    ie = ~ie;
  endtask
  task automatic cfg();
    @(negedge mclk);
    cfg_reset = 1;
    @(negedge mclk);
    cfg_reset = 0;
  endtask
endmodule // wiso_host

// [testbench/wiso_endpoint_test.sv]
`timescale 1ns/1ps

module wiso_endpoint_test;
  import wiso_pkg::*;
  logic mclk = 0;
  logic reset_n = 0;
  logic [7:0] alt_setting = 8'h00;
  logic [4:0] interval_req = 5'h06;
  logic src_valid = 0;
  logic [31:0] src_data;
  logic sink_ready = 0;
  logic in_req, in_ack, out_valid, ie_valid, cfg_reset;
  pkt_t out_pkt, in_rsp_pkt;
  ie_t ie;
  hs_t out_hs;
  logic [15:0] max_packet_size;
  logic [4:0] interval_code;
  logic [31:0] interval_cycles, sink_data;
  logic [7:0] lost_count;
  logic ep_ready_notify, in_discard, in_rsp_valid, in_rsp_nak;
  logic out_hs_valid, sink_valid, ie_confirm;
  int errors = 0;
  int checked = 0;
  int drops = 0;
  int confirms = 0;
  int c;
  logic [37:0] e;
  logic [37:0] q_in[$];
  hs_t q_hs[$];
  logic [31:0] q_sink[$];
  logic [31:0] w[$];
  logic [4:0] iseq = 5'h00;

  always #5 mclk = ~mclk;

  wiso_endpoint #(.IN_DEPTH(4), .OUT_DEPTH(2), .UNIT_CYCLES(4)) u_dut (
    .mclk, .reset_n, .alt_setting, .interval_req, .cfg_reset,
    .max_packet_size, .interval_code, .interval_cycles, .ep_ready_notify,
    .src_valid, .src_data, .in_discard, .in_req, .in_ack, .in_rsp_valid,
    .in_rsp_nak, .in_rsp_pkt, .out_valid, .out_pkt, .out_hs_valid,
    .out_hs, .sink_valid, .sink_ready, .sink_data, .ie_valid, .ie,
    .ie_confirm, .lost_count
  );
  wiso_host u_host (
    .mclk, .in_req, .in_ack, .out_valid, .out_pkt, .ie_valid, .ie,
    .cfg_reset
  );
  // --
  // helpers
  // --
  function automatic bit bad(input bit b);
    checked++;
    return b;
  endfunction
  task automatic err(input string m);
    errors++;
    $display("ERROR %0t %s", $time, m);
  endtask
  task automatic conclude();
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic push(input int n);
    repeat (n) begin
      @(negedge mclk);
      src_valid = 1;
      src_data = $urandom;
      w.push_back(src_data);
    end
    @(negedge mclk);
    src_valid = 0;
  endtask
  task automatic tok(input logic nak);
    q_in.push_back(nak ? {1'b1, 37'h0} : {1'b0, iseq, w[0]});
    u_host.tok(1'b0);
  endtask
  task automatic ox(input logic [4:0] s, input hs_t h, input bit st);
    logic [31:0] d;
    d = $urandom;
    q_hs.push_back(h);
    if (st) q_sink.push_back(d);
    u_host.out(s, d);
  endtask
  // --
  // result monitor
  // --
  always @(posedge mclk) begin
    if (reset_n && in_rsp_valid) begin
      e = q_in.pop_front();
      if (bad(in_rsp_nak !== e[37])) err("nak flag");
      if (!e[37] && bad(in_rsp_pkt !== e[36:0])) err("in packet");
    end
    if (reset_n && out_hs_valid) begin
      if (bad(out_hs !== q_hs.pop_front())) err("handshake");
    end
    if (reset_n && sink_valid && sink_ready) begin
      if (bad(sink_data !== q_sink.pop_front())) err("sink word");
    end
    if (reset_n) begin
      drops += in_discard;
      confirms += ie_confirm;
    end
  end
  // --
  // tests
  // --
  initial begin
    src_data = $urandom(4);
    repeat (16) @(negedge mclk);
    reset_n = 1;
    for (int i = 0; i < 3; i++) begin
      alt_setting = i == 1 ? 8'($urandom_range(255, 1)) : 8'h00;
      repeat (2) @(negedge mclk);
      c = i == 1 ? 16'h0200 : 16'h0000;
      if (bad(max_packet_size !== 16'(c))) err("size");
    end
    for (int x = 0; x < 21; x++) begin
      interval_req = 5'(x);
      repeat (2) @(negedge mclk);
      c = x < 6 ? 6 : (x > 16 ? 16 : x);
      if (bad(interval_code !== 5'(c))) err("code");
      if (bad(interval_cycles !== 32'(4 << (c - 1)))) err("len");
    end
    tok(1'b1);
    push(1);
    tok(1'b0);
    tok(1'b0);
    u_host.tok(1'b1);
    void'(w.pop_front());
    iseq++;
    tok(1'b1);
    push(4);
    tok(1'b0);
    push(1);
    void'(w.pop_front());
    u_host.tok(1'b1);
    tok(1'b0);
    repeat (2) @(negedge mclk);
    if (bad(drops !== 1)) err("drop count");
    ox(5'h00, HS_ACK, 1'b1);
    ox(5'h01, HS_ACK, 1'b1);
    ox(5'h02, HS_NAK, 1'b0);
    ox(5'h01, HS_ACK, 1'b0);
    ox(5'h09, HS_NAK, 1'b0);
    repeat (6) begin
      sink_ready = 1'($urandom);
      @(negedge mclk);
    end
    sink_ready = 1;
    repeat (3) @(negedge mclk);
    ox(5'h02, HS_ACK, 1'b1);
    u_host.disc(1'b1, 5'h07, 8'h03);
    ox(5'h07, HS_ACK, 1'b1);
    u_host.disc(1'b0, 5'h0c, 8'h03);
    ox(5'h08, HS_ACK, 1'b1);
    u_host.disc(1'b1, 5'h14, 8'h02);
    ox(5'h14, HS_ACK, 1'b1);
    if (bad(lost_count !== 8'h05)) err("lost count");
    if (bad(confirms !== 3)) err("confirm count");
    u_host.cfg();
    w.delete();
    iseq = 5'h00;
    ox(5'h00, HS_ACK, 1'b1);
    push(1);
    tok(1'b0);
    repeat (4) @(negedge mclk);
    c = q_in.size() + q_hs.size() + q_sink.size();
    if (bad(c != 0)) err("missing answers");
    conclude();
  end
  initial begin
    #50us;
    err("timeout");
    conclude();
  end
endmodule // wiso_endpoint_test
